// ===== logic/fpl_defines.vh
// fpl_defines.vh - constants for the fault policy and status indicator block
`ifndef FPL_DEFINES_VH
`define FPL_DEFINES_VH

// --------
// clock and timing
// --------
`define FPL_CLK_HZ 20000000
`define FPL_TICK_MS 1
`define FPL_TICK_CYC (`FPL_CLK_HZ / 1000 * `FPL_TICK_MS)
`define FPL_SLOW_MS_RST 16'h01F4
`define FPL_FAST_MS_RST 16'h007D

// --------
// register byte offsets
// --------
`define FPL_A_CTRL 12'h000
`define FPL_A_STAT 12'h004
`define FPL_A_MASK 12'h008
`define FPL_A_SLOW 12'h00C
`define FPL_A_FAST 12'h010
`define FPL_A_IND 12'h014
`define FPL_A_SWACK 12'h018
`define FPL_T_RESP 2'h1
`define FPL_T_ACK 2'h2
`define FPL_T_MSG 2'h3

// --------
// table geometry and entry layout
// --------
`define FPL_NENT 20
`define FPL_NUM_MSB 15
`define FPL_SET_LSB 16
`define FPL_SET_MSB 19

// --------
// control register fields
// --------
`define FPL_C_READY 0
`define FPL_C_COMM 1
`define FPL_C_FWUPD 2
`define FPL_C_FWDONE 3
`define FPL_C_FWFLT 4
`define FPL_C_INCOMP 5
`define FPL_C_GENFLT 6
`define FPL_C_CYCLIC 7
`define FPL_C_CFGFLT 8
`define FPL_C_NODATA 9
`define FPL_C_BAUD 10
`define FPL_C_CONN 11
`define FPL_C_LINK 12
`define FPL_C_PROT_LSB 16
`define FPL_C_PROT_MSB 23

// --------
// settings encodings
// --------
`define FPL_ACK_DEFAULT 4'h0
`define FPL_ACK_POWERON 4'h1
`define FPL_ACK_CAUSE 4'h2
`define FPL_MSG_FAULT 4'h1
`define FPL_MSG_ALARM 4'h2
`define FPL_MSG_NONE 4'h3
`define FPL_PROT_UNUSED 8'h00

// --------
// status bits
// --------
`define FPL_S_FAULT 0
`define FPL_S_ALARM 1
`define FPL_S_CLEAR 2
`define FPL_S_W 3

`endif

// ===== logic/fpl_top.v
// fpl_top.v - fault policy tables and status indicator encoder
`timescale 1ns/1ns
`include "fpl_defines.vh"

// Function
// R1 - twenty-entry fault response override table
// R2 - twenty-entry acknowledgement mode override table
// R3 - mode 1 power-on only, 2 clears when gone
// R4 - twenty-entry message type override table
// R5 - type 1 fault, 2 alarm, 3 suppressed
// R6 - ready, no fault: ready indicator steady green
// R7 - commissioning or factory reset: slow green flash
// R8 - firmware update: ready red, bus orange slow
// R9 - update done: both indicators slow red flash
// R10 - general fault: ready fast red flash
// R11 - fault during update: fast red, bus steady red
// R12 - incompatible firmware: both fast red flash
// R13 - fieldbus off when cyclic or protocol zero
// R14 - fieldbus configuration fault: slow red flash
// R15 - no data, baud fail, lost: fast red
// R16 - link indicator on only while link active
// R17 - flash rates from counters, fast below slow
// R18 - fixed priority: firmware and faults first
module fpl_top #(
    parameter TICK_CYC = `FPL_TICK_CYC
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // ahb-lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata_r,
    output reg hreadyout_r,
    output reg hresp_r,
    // fault event side
    input wire flt_valid,
    input wire [15:0] flt_code,
    input wire flt_cause_gone,
    output reg [3:0] flt_resp_r,
    output reg flt_resp_hit_r,
    output reg flt_active_r,
    output reg alarm_active_r,
    // indicators
    output reg rdy_green_r,
    output reg rdy_red_r,
    output reg bus_fault_green_r,
    output reg bus_fault_red_r,
    output reg link_indicator_r,
    output reg irq_r
);

    // ----------------------------------------------------------------
    // indicator states, one-hot, highest priority first
    // ----------------------------------------------------------------
    localparam [7:0] ST_INCOMP = 8'h80;
    localparam [7:0] ST_FWFLT = 8'h40;
    localparam [7:0] ST_FWUPD = 8'h20;
    localparam [7:0] ST_FWDONE = 8'h10;
    localparam [7:0] ST_GENFLT = 8'h08;
    localparam [7:0] ST_COMM = 8'h04;
    localparam [7:0] ST_READY = 8'h02;
    localparam [7:0] ST_OFF = 8'h01;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg [31:0] ctrl_r; // converter and bus state bits
    reg [`FPL_S_W-1:0] stat_r; // sticky events
    reg [`FPL_S_W-1:0] mask_r; // interrupt enables
    reg [15:0] slow_ms_r; // slow half period
    reg [15:0] fast_ms_r; // fast half period
    reg [`FPL_NUM_MSB:0] resp_num [0:`FPL_NENT-1];
    reg [3:0] resp_set [0:`FPL_NENT-1];
    reg [`FPL_NUM_MSB:0] ack_num [0:`FPL_NENT-1];
    reg [3:0] ack_set [0:`FPL_NENT-1];
    reg [`FPL_NUM_MSB:0] msg_num [0:`FPL_NENT-1];
    reg [3:0] msg_set [0:`FPL_NENT-1];
    reg [3:0] flt_ack_r; // ack mode of latched fault
    reg [7:0] st_r; // indicator state
    reg [7:0] st_nxt;

    // bus phase
    reg ph_r; // data phase pending
    reg [11:0] adr_r;
    reg wr_r;

    // flash timing
    reg [15:0] tick_cnt_r;
    reg tick_r;
    reg [15:0] slow_cnt_r;
    reg [15:0] fast_cnt_r;
    reg slow_ph_r;
    reg fast_ph_r;
    wire [15:0] fast_eff;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // table select from byte address
    function [1:0] tsel;
        input [11:0] a;
        begin
            tsel = a[9:8];
        end
    endfunction

    // entry index is valid inside a table
    function ent_ok;
        input [11:0] a;
        begin
            ent_ok = (a[11:10] == 2'h0) && (tsel(a) != 2'h0) && (a[7:2] < `FPL_NENT) && (a[1:0] == 2'h0);
        end
    endfunction

    // entry word layout
    function [31:0] ent_word;
        input [15:0] n;
        input [3:0] s;
        begin
            ent_word = {12'h000, s, n};
        end
    endfunction

    // ----------------------------------------------------------------
    // ahb-lite slave: one wait state, then okay
    // ----------------------------------------------------------------
    wire acc = hsel & htrans[1] & hready & hreadyout_r;
    wire do_wr = ph_r & wr_r;
    wire [4:0] idx = adr_r[6:2];
    wire [31:0] wd = hwdata;

    // address phase capture and handshake
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ph_r <= 1'b0;
            adr_r <= 12'h000;
            wr_r <= 1'b0;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else if (acc) begin
            ph_r <= 1'b1;
            adr_r <= haddr;
            wr_r <= hwrite;
            hreadyout_r <= 1'b0; // stall while data resolves
        end else begin
            ph_r <= 1'b0;
            hreadyout_r <= 1'b1;
        end
    end

    // read data, unmapped reads zero
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            hrdata_r <= 32'h00000000;
        end else if (ph_r && !wr_r) begin
            if (ent_ok(adr_r)) begin
                case (tsel(adr_r))
                    `FPL_T_RESP: hrdata_r <= ent_word(resp_num[idx], resp_set[idx]);
                    `FPL_T_ACK: hrdata_r <= ent_word(ack_num[idx], ack_set[idx]);
                    default: hrdata_r <= ent_word(msg_num[idx], msg_set[idx]);
                endcase
            end else begin
                case (adr_r)
                    `FPL_A_CTRL: hrdata_r <= ctrl_r;
                    `FPL_A_STAT: hrdata_r <= {29'h00000000, stat_r};
                    `FPL_A_MASK: hrdata_r <= {29'h00000000, mask_r};
                    `FPL_A_SLOW: hrdata_r <= {16'h0000, slow_ms_r};
                    `FPL_A_FAST: hrdata_r <= {16'h0000, fast_ms_r};
                    `FPL_A_IND: hrdata_r <= {14'h0000, flt_active_r, alarm_active_r, 3'h0,
                        link_indicator_r, bus_fault_red_r, bus_fault_green_r, rdy_red_r, rdy_green_r, st_r};
                    default: hrdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // plain registers
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r <= 32'h00000000;
            mask_r <= 3'h0;
            slow_ms_r <= `FPL_SLOW_MS_RST;
            fast_ms_r <= `FPL_FAST_MS_RST;
        end else if (do_wr) begin
            case (adr_r)
                `FPL_A_CTRL: ctrl_r <= wd;
                `FPL_A_MASK: mask_r <= wd[`FPL_S_W-1:0];
                `FPL_A_SLOW: slow_ms_r <= wd[15:0];
                `FPL_A_FAST: fast_ms_r <= wd[15:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // override tables, number zero marks an empty entry
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `FPL_NENT; g = g + 1) begin : g_tab
            // one entry of each table
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    resp_num[g] <= 16'h0000;
                    resp_set[g] <= 4'h0;
                    ack_num[g] <= 16'h0000;
                    ack_set[g] <= 4'h0;
                    msg_num[g] <= 16'h0000;
                    msg_set[g] <= 4'h0;
                end else if (do_wr && ent_ok(adr_r) && idx == g) begin
                    case (tsel(adr_r))
                        `FPL_T_RESP: begin // [R1]
                            resp_num[g] <= wd[`FPL_NUM_MSB:0];
                            resp_set[g] <= wd[`FPL_SET_MSB:`FPL_SET_LSB];
                        end
                        `FPL_T_ACK: begin // [R2]
                            ack_num[g] <= wd[`FPL_NUM_MSB:0];
                            ack_set[g] <= wd[`FPL_SET_MSB:`FPL_SET_LSB];
                        end
                        default: begin // [R4]
                            msg_num[g] <= wd[`FPL_NUM_MSB:0];
                            msg_set[g] <= wd[`FPL_SET_MSB:`FPL_SET_LSB];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // lookup of incoming fault code, last matching entry wins
    // ----------------------------------------------------------------
    reg [3:0] lk_resp;
    reg lk_rhit;
    reg [3:0] lk_ack;
    reg [3:0] lk_msg;
    integer i;
    always @* begin
        lk_resp = 4'h0;
        lk_rhit = 1'b0;
        lk_ack = `FPL_ACK_DEFAULT;
        lk_msg = `FPL_MSG_FAULT; // unlisted codes report as fault
        for (i = 0; i < `FPL_NENT; i = i + 1) begin
            if (resp_num[i] != 16'h0000 && resp_num[i] == flt_code) begin // [R1]
                lk_resp = resp_set[i];
                lk_rhit = 1'b1;
            end
            if (ack_num[i] != 16'h0000 && ack_num[i] == flt_code) begin // [R2]
                lk_ack = ack_set[i];
            end
            if (msg_num[i] != 16'h0000 && msg_num[i] == flt_code) begin // [R4]
                lk_msg = msg_set[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // fault and alarm state with policy applied
    // ----------------------------------------------------------------
    wire sw_ack = do_wr && adr_r == `FPL_A_SWACK && wd[0];
    wire ev_flt = flt_valid && lk_msg == `FPL_MSG_FAULT; // [R5]
    wire ev_alm = flt_valid && lk_msg == `FPL_MSG_ALARM; // [R5]
    // power-on mode never clears here; cause mode clears on cause gone
    wire flt_clr = flt_active_r && !ev_flt &&
        ((flt_ack_r == `FPL_ACK_CAUSE && flt_cause_gone) ||
         (flt_ack_r == `FPL_ACK_DEFAULT && sw_ack)); // [R3]

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            flt_active_r <= 1'b0;
            flt_ack_r <= `FPL_ACK_DEFAULT;
            alarm_active_r <= 1'b0;
            flt_resp_r <= 4'h0;
            flt_resp_hit_r <= 1'b0;
        end else begin
            if (ev_flt) begin
                flt_active_r <= 1'b1;
                // a sticky power-on fault stays sticky
                if (!(flt_active_r && flt_ack_r == `FPL_ACK_POWERON)) begin // [R3]
                    flt_ack_r <= lk_ack;
                end
                flt_resp_r <= lk_resp; // [R1]
                flt_resp_hit_r <= lk_rhit;
            end else if (flt_clr) begin
                flt_active_r <= 1'b0;
            end
            // alarms go away with their cause
            if (ev_alm) begin
                alarm_active_r <= 1'b1;
            end else if (flt_cause_gone) begin
                alarm_active_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky status, write one to clear, set wins
    // ----------------------------------------------------------------
    wire [`FPL_S_W-1:0] ev_set = {flt_clr, ev_alm, ev_flt};
    wire [`FPL_S_W-1:0] w1c = (do_wr && adr_r == `FPL_A_STAT) ? wd[`FPL_S_W-1:0] : 3'h0;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stat_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= (stat_r & ~w1c) | ev_set;
            irq_r <= |(((stat_r & ~w1c) | ev_set) & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // flash rate generation
    // ----------------------------------------------------------------
    // fast period forced below slow when misconfigured
    assign fast_eff = (fast_ms_r != 16'h0000 && fast_ms_r < slow_ms_r) ? fast_ms_r :
        ((slow_ms_r >> 2) == 16'h0000 ? 16'h0001 : (slow_ms_r >> 2)); // [R17]

    // millisecond tick
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYC - 1) begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // slow and fast phase toggles
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            slow_cnt_r <= 16'h0000;
            fast_cnt_r <= 16'h0000;
            slow_ph_r <= 1'b0;
            fast_ph_r <= 1'b0;
        end else if (tick_r) begin
            if (slow_cnt_r + 16'h0001 >= slow_ms_r) begin // [R17]
                slow_cnt_r <= 16'h0000;
                slow_ph_r <= ~slow_ph_r;
            end else begin
                slow_cnt_r <= slow_cnt_r + 16'h0001;
            end
            if (fast_cnt_r + 16'h0001 >= fast_eff) begin // [R17]
                fast_cnt_r <= 16'h0000;
                fast_ph_r <= ~fast_ph_r;
            end else begin
                fast_cnt_r <= fast_cnt_r + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // indicator state selection by fixed priority
    // ----------------------------------------------------------------
    wire gen_flt = ctrl_r[`FPL_C_GENFLT] | flt_active_r;
    always @* begin
        if (ctrl_r[`FPL_C_INCOMP]) begin // [R18]
            st_nxt = ST_INCOMP;
        end else if (ctrl_r[`FPL_C_FWFLT]) begin
            st_nxt = ST_FWFLT;
        end else if (ctrl_r[`FPL_C_FWUPD]) begin
            st_nxt = ST_FWUPD;
        end else if (ctrl_r[`FPL_C_FWDONE]) begin
            st_nxt = ST_FWDONE;
        end else if (gen_flt) begin
            st_nxt = ST_GENFLT;
        end else if (ctrl_r[`FPL_C_COMM]) begin
            st_nxt = ST_COMM;
        end else if (ctrl_r[`FPL_C_READY]) begin
            st_nxt = ST_READY;
        end else begin
            st_nxt = ST_OFF;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // indicator encoding
    // ----------------------------------------------------------------
    wire prot_off = ctrl_r[`FPL_C_PROT_MSB:`FPL_C_PROT_LSB] == `FPL_PROT_UNUSED;
    wire fb_fast = ctrl_r[`FPL_C_NODATA] | ctrl_r[`FPL_C_BAUD] | ctrl_r[`FPL_C_CONN];
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rdy_green_r <= 1'b0;
            rdy_red_r <= 1'b0;
            bus_fault_green_r <= 1'b0;
            bus_fault_red_r <= 1'b0;
            link_indicator_r <= 1'b0;
        end else begin
            rdy_green_r <= 1'b0;
            rdy_red_r <= 1'b0;
            bus_fault_green_r <= 1'b0;
            bus_fault_red_r <= 1'b0;
            // fieldbus state when no general state owns the bus indicator
            if (prot_off || ctrl_r[`FPL_C_CYCLIC]) begin
                bus_fault_red_r <= 1'b0; // [R13]
            end else if (ctrl_r[`FPL_C_CFGFLT]) begin
                bus_fault_red_r <= slow_ph_r; // [R14]
            end else if (fb_fast) begin
                bus_fault_red_r <= fast_ph_r; // [R15]
            end
            case (st_r)
                ST_INCOMP: begin
                    rdy_red_r <= fast_ph_r; // [R12]
                    bus_fault_red_r <= fast_ph_r;
                end
                ST_FWFLT: begin
                    rdy_red_r <= fast_ph_r; // [R11]
                    bus_fault_red_r <= 1'b1;
                end
                ST_FWUPD: begin
                    rdy_red_r <= 1'b1; // [R8]
                    bus_fault_red_r <= slow_ph_r;
                    bus_fault_green_r <= slow_ph_r;
                end
                ST_FWDONE: begin
                    rdy_red_r <= slow_ph_r; // [R9]
                    bus_fault_red_r <= slow_ph_r;
                end
                ST_GENFLT: rdy_red_r <= fast_ph_r; // [R10]
                ST_COMM: rdy_green_r <= slow_ph_r; // [R7]
                ST_READY: rdy_green_r <= 1'b1; // [R6]
                ST_OFF: rdy_green_r <= 1'b0;
                default: rdy_green_r <= 1'b0;
            endcase
            link_indicator_r <= ctrl_r[`FPL_C_LINK]; // [R16]
        end
    end

endmodule // fpl_top

// ===== sim/fpl_chk_asserts.sv
// port checker for the fault policy and indicator block
`timescale 1ns/1ns
module fpl_chk (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // bus handshake
    input wire hsel,
    input wire [1:0] htrans,
    input wire hready,
    input wire hreadyout_r,
    // fault side
    input wire flt_valid,
    input wire flt_resp_hit_r,
    input wire flt_active_r,
    input wire alarm_active_r,
    // indicators
    input wire rdy_green_r,
    input wire rdy_red_r,
    input wire bus_fault_green_r,
    input wire bus_fault_red_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // --------
    // bus handshake
    // --------
    bus_wait_a: assert property (hsel && htrans[1] && hready && hreadyout_r |=> !hreadyout_r ##1 hreadyout_r)
        else $error("no single wait cycle");
    wait_short_a: assert property (!hreadyout_r |=> hreadyout_r)
        else $error("long wait");
    // --------
    // fault events
    // --------
    resp_hit_cause_a: assert property ($rose(flt_resp_hit_r) |-> $past(flt_valid))
        else $error("stray hit");
    fault_cause_a: assert property ($rose(flt_active_r) |-> $past(flt_valid))
        else $error("stray fault");
    alarm_cause_a: assert property ($rose(alarm_active_r) |-> $past(flt_valid))
        else $error("stray alarm");
    // --------
    // indicators
    // --------
    ready_colour_a: assert property (!(rdy_green_r && rdy_red_r))
        else $error("ready both colours");
    bus_orange_a: assert property (bus_fault_green_r |-> bus_fault_red_r)
        else $error("green without red");
    fault_no_green_a: assert property (flt_active_r [*4] |-> !rdy_green_r)
        else $error("green in fault");
    // main scenarios reached
    cover property ($rose(flt_active_r));
    cover property ($rose(alarm_active_r));
    cover property (bus_fault_green_r && bus_fault_red_r);
endmodule // fpl_chk

bind fpl_top fpl_chk chk_u (.clk_sys, .rst_n, .hsel, .htrans, .hready, .hreadyout_r, .flt_valid, .flt_resp_hit_r,
    .flt_active_r, .alarm_active_r, .rdy_green_r, .rdy_red_r, .bus_fault_green_r, .bus_fault_red_r);

// ===== sim/fpl_evt_src.sv
// fault event source standing in for the converter monitoring
`timescale 1ns/1ns
module fpl_evt_src (
    // clock
    input wire clk_sys,
    // requests from the bench
    input wire req,
    input wire [15:0] req_code,
    input wire gone_req,
    // fault event port
    output reg flt_valid_r = 1'b0,
    output reg [15:0] flt_code_r = 16'h0000,
    output reg flt_cause_gone_r = 1'b0
);
    // one event per request cycle; code not held outside an event
    always @(posedge clk_sys) begin
        flt_valid_r <= req;
        flt_code_r <= req ? req_code : ~flt_code_r;
        flt_cause_gone_r <= gone_req;
    end
endmodule // fpl_evt_src

// ===== sim/fpl_top_tb.sv
// self-checking bench for the fault policy and indicator block
`timescale 1ns/1ns
`include "fpl_defines.vh"
module fpl_top_tb;
    // --------
    // stimulus and observed signals
    // --------
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg hsel = 1'b0;
    reg [11:0] haddr = 12'h000;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg req = 1'b0;
    reg [15:0] req_code = 16'h0000;
    reg gone_req = 1'b0;
    wire [2:0] hsize = 3'h2;
    wire [31:0] hrdata_r;
    wire [15:0] flt_code;
    wire [3:0] flt_resp_r;
    wire hreadyout_r, hresp_r, flt_valid, flt_cause_gone, flt_resp_hit_r, flt_active_r, alarm_active_r;
    wire rdy_green_r, rdy_red_r, bus_fault_green_r, bus_fault_red_r, link_indicator_r, irq_r;
    wire hready = hreadyout_r;
    wire [4:0] leds = {link_indicator_r, rdy_green_r, rdy_red_r, bus_fault_green_r, bus_fault_red_r};
    wire [7:0] fst = {flt_resp_r, flt_resp_hit_r, flt_active_r, alarm_active_r, irq_r};
    integer err_count = 0;
    integer comparisons = 0;
    fpl_top #(.TICK_CYC(4)) dut_u (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata_r, .hreadyout_r, .hresp_r, .flt_valid, .flt_code, .flt_cause_gone, .flt_resp_r, .flt_resp_hit_r,
        .flt_active_r, .alarm_active_r, .rdy_green_r, .rdy_red_r, .bus_fault_green_r, .bus_fault_red_r,
        .link_indicator_r, .irq_r);
    fpl_evt_src evt_u (.clk_sys, .req, .req_code, .gone_req, .flt_valid_r(flt_valid), .flt_code_r(flt_code),
        .flt_cause_gone_r(flt_cause_gone));
    // 50 ns clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // --------
    // tasks
    // --------
    task report_and_stop;
        begin
            $display("comparisons=%0d err_count=%0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            comparisons++;
            if (seen !== exp) begin
                err_count++;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // waits for a ready edge, bounded
    task wait_rdy;
        integer n;
        begin
            n = 0;
            @(posedge clk_sys);
            while (hreadyout_r !== 1'b1) begin
                n++;
                if (n > 20) begin
                    err_count++;
                    report_and_stop;
                end
                @(posedge clk_sys);
            end
        end
    endtask
    // one single word transfer
    task ahb(input [11:0] a, input w, input [31:0] d, output [31:0] q);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            wait_rdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            wait_rdy;
            q = hrdata_r;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        reg [31:0] q;
        begin
            ahb(a, 1'b1, d, q);
        end
    endtask
    task rdc(input [11:0] a, input [31:0] e);
        reg [31:0] q;
        begin
            ahb(a, 1'b0, 32'h0, q);
            chk(q, e);
        end
    endtask
    // event or cause-gone pulse through the source model
    task evt(input [15:0] c, input g);
        begin
            req <= !g;
            req_code <= c;
            gone_req <= g;
            @(posedge clk_sys);
            req <= 1'b0;
            gone_req <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    // 0 off, 1 steady, 2 slow, 3 fast
    function [1:0] pat(input integer o, input integer t);
        begin
            pat = (o == 0) ? 2'h0 : (o == 16) ? 2'h1 : (o == 8 && t == 2) ? 2'h2 : (o == 8 && t == 4) ? 2'h3 : 2'hX;
        end
    endfunction
    // classify each colour indicator over 16 cycles, link taken at the last cycle
    task led_chk(input [31:0] ctrl, input [8:0] exp);
        integer ones [0:3];
        integer tog [0:3];
        integer i, k;
        reg [4:0] prev, cur;
        begin
            wr(`FPL_A_CTRL, ctrl);
            repeat (10) @(posedge clk_sys);
            for (k = 0; k < 4; k++) begin
                ones[k] = 0;
                tog[k] = 0;
            end
            prev = leds;
            for (i = 0; i < 16; i++) begin
                @(posedge clk_sys);
                cur = leds;
                for (k = 0; k < 4; k++) begin
                    ones[k] += prev[k];
                    tog[k] += (cur[k] != prev[k]);
                end
                prev = cur;
            end
            chk({cur[4], pat(ones[3], tog[3]), pat(ones[2], tog[2]), pat(ones[1], tog[1]), pat(ones[0], tog[0])}, exp);
        end
    endtask
    // --------
    // main sequence
    // --------
    initial begin
        integer i;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk(leds, 5'h00);
        rdc(`FPL_A_SLOW, 32'h1F4);
        rdc(`FPL_A_FAST, 32'h7D);
        wr(`FPL_A_SLOW, 32'h2);
        wr(`FPL_A_FAST, 32'h1);
        led_chk(32'h1, 9'h040);
        led_chk(32'h2, 9'h080);
        led_chk(32'h4, 9'h01A);
        led_chk(32'h8, 9'h022);
        led_chk(32'h41, 9'h030);
        led_chk(32'h14, 9'h031);
        led_chk(32'h3C, 9'h033);
        led_chk(32'h11081, 9'h140);
        led_chk(32'h1201, 9'h140);
        led_chk(32'h10101, 9'h042);
        led_chk(32'h10201, 9'h043);
        led_chk(32'h10401, 9'h043);
        led_chk(32'h10801, 9'h043);
        wr(`FPL_A_CTRL, 32'h0);
        // last entry of each table, stray upper bits dropped
        wr(12'h14C, 32'hFFF51234);
        rdc(12'h14C, 32'h51234);
        wr(12'h24C, 32'hABC20777);
        rdc(12'h24C, 32'h20777);
        wr(12'h34C, 32'h20A02);
        rdc(12'h34C, 32'h20A02);
        wr(12'h200, 32'h10888);
        wr(12'h300, 32'h30A03);
        wr(12'h304, 32'h10A01);
        // index 20 of each table is unmapped
        for (i = 1; i < 4; i++) begin
            wr({i[3:0], 8'h50}, 32'hFFFFFFFF);
            rdc({i[3:0], 8'h50}, 32'h0);
        end
        wr(`FPL_A_MASK, 32'h1);
        evt(16'h1234, 1'b0);
        chk(fst, 8'h5D);
        evt(16'h0, 1'b1);
        chk(fst, 8'h5D);
        wr(`FPL_A_SWACK, 32'h1);
        chk(fst, 8'h59);
        rdc(`FPL_A_STAT, 32'h5);
        wr(`FPL_A_MASK, 32'h0);
        @(posedge clk_sys);
        chk(fst, 8'h58);
        wr(`FPL_A_STAT, 32'h7);
        rdc(`FPL_A_STAT, 32'h0);
        evt(16'h0A02, 1'b0);
        chk(fst, 8'h5A);
        evt(16'h0, 1'b1);
        chk(fst, 8'h58);
        evt(16'h0A03, 1'b0);
        chk(fst, 8'h58);
        evt(16'h0A01, 1'b0);
        chk(fst, 8'h04);
        wr(`FPL_A_SWACK, 32'h1);
        evt(16'h0777, 1'b0);
        chk(fst, 8'h04);
        evt(16'h0, 1'b1);
        chk(fst, 8'h00);
        evt(16'h0888, 1'b0);
        evt(16'h0, 1'b1);
        wr(`FPL_A_SWACK, 32'h1);
        chk(fst, 8'h04);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk(fst, 8'h00);
        report_and_stop;
    end
endmodule // fpl_top_tb
